/* logic/dpm_peak_counter.sv */
`timescale 1ns/1ps
module dpm_peak_counter (
    input  wire logic                  clk_i,
    input  wire logic                  rst_b_i,
    input  wire dpm_pkg::dpm_peak_cfg_s cfg_i,
    input  wire logic [1:0]            ovf_sel_i,
    input  wire dpm_pkg::dpm_sample_s  sample_i,
    input  wire dpm_pkg::dpm_ovf_s     ovf_i,
    input  wire logic                  sync_i,
    output logic [7:0]                 result_o,
    output logic                       period_o,
    output logic                       sat_o
);

    // ==========================================================
    // qualifying event
    // ==========================================================
    logic [7:0]  tally_r;
    logic [7:0]  tally_nxt;
    logic [7:0]  result_r;
    logic        period_r;
    logic        sat_r;
    wire  signed [10:0] top_bits = sample_i.data[15:5];      // see RULE_03
    wire  [11:0] magnitude = top_bits[10] ?
                             12'(-$signed({top_bits[10], top_bits})) :
                             {1'b0, top_bits};               // see RULE_03
    wire  [11:0] threshold = 12'(({10'h000, cfg_i.level_limit_code}
                             + 12'h001) * dpm_pkg::LEVEL_STEP); // see RULE_02
    wire         level_hit = sample_i.valid &&
                             (magnitude >= threshold);       // see RULE_03
    wire         ovf_hit   = (ovf_sel_i == dpm_pkg::OVF_COMP) ?
                                 ovf_i.compensation_filter :
                             (ovf_sel_i == dpm_pkg::OVF_COARSE) ?
                                 ovf_i.coarse_gain :
                                 ovf_i.programmable_filter;  // see RULE_11
    wire         hit       = cfg_i.mode ? ovf_hit : level_hit; // see RULE_04
    wire         at_max    = (tally_r == dpm_pkg::TALLY_MAX);

    // ==========================================================
    // tally: an event in the sync cycle opens the new period
    // ==========================================================
    assign tally_nxt =
        sync_i           ? {7'h00, hit}    :    // see RULE_01
        (hit && !at_max) ? tally_r + 8'h01 :    // see RULE_12
                           tally_r;             // see RULE_05

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tally_r  <= 8'h00;
            result_r <= 8'h00;
            period_r <= 1'b0;
            sat_r    <= 1'b0;
        end else begin
            tally_r  <= tally_nxt;
            if (sync_i) begin
                result_r <= tally_r;                         // see RULE_06
            end
            period_r <= sync_i;
            sat_r    <= !sync_i && hit &&
                        (tally_r == dpm_pkg::TALLY_MAX - 8'h01);
        end
    end

    assign result_o = result_r;
    assign period_o = period_r;
    assign sat_o    = sat_r;

endmodule

/* logic/dpm_pkg.sv */
package dpm_pkg;

    // ==========================================================
    // register indices (byte address is four times the index)
    // ==========================================================
    localparam logic [5:0] IDX_PEAK_CTRL   = 6'h1c;
    localparam logic [5:0] IDX_PEAK_RESULT = 6'h1d;
    localparam logic [5:0] IDX_TRIM_LO     = 6'h1e;
    localparam logic [5:0] IDX_TRIM_HI     = 6'h1f;
    localparam logic [5:0] IDX_IRQ_STATUS  = 6'h20;
    localparam logic [5:0] IDX_IRQ_MASK    = 6'h21;
    localparam logic [5:0] IDX_GAIN_SYNC   = 6'h22;

    // ==========================================================
    // reset values
    // ==========================================================
    localparam logic [7:0] RST_PEAK_CTRL = 8'h1d;
    localparam logic [7:0] RST_TRIM_LO   = 8'h00;
    localparam logic [7:0] RST_TRIM_HI   = 8'h00;
    localparam logic [2:0] RST_GAIN_SYNC = 3'h0;
    localparam logic [2:0] RST_IRQ       = 3'h0;

    // ==========================================================
    // field layouts and widths
    // ==========================================================
    localparam int SAMPLE_W   = 16;
    localparam int TOP_BITS   = 11;
    localparam int GAIN_W     = 14;
    localparam int GAIN_SHIFT = 10;
    localparam int TRIM_HI_W  = 6;
    localparam int TALLY_W    = 8;
    localparam int N_SYNC     = 8;
    localparam int N_IRQ      = 3;

    localparam logic [7:0]  TALLY_MAX  = 8'hff;
    localparam logic [11:0] LEVEL_STEP = 12'h100;

    // interrupt status bit positions
    localparam int IRQ_PERIOD = 0;
    localparam int IRQ_GAIN   = 1;
    localparam int IRQ_SAT    = 2;

    // overflow source codes
    localparam logic [1:0] OVF_COMP   = 2'h0;
    localparam logic [1:0] OVF_COARSE = 2'h1;

    typedef struct packed {
        logic [1:0] unused;
        logic       mode;
        logic [1:0] level_limit_code;
        logic [2:0] sync_sel;
    } dpm_peak_cfg_s;

    typedef struct packed {
        logic                       valid;
        logic signed [SAMPLE_W-1:0] data;
    } dpm_sample_s;

    typedef struct packed {
        logic programmable_filter;
        logic coarse_gain;
        logic compensation_filter;
    } dpm_ovf_s;

endpackage

/* logic/dpm_top.sv */
// Contract
// RULE_01 - selected peak sync moves tally, clears it (code loads it with the sync-cycle event, so it restarts at 0 or 1)
// RULE_02 - level code picks quarter to full scale
// RULE_03 - abs of top eleven bits versus threshold
// RULE_04 - mode zero counts samples, one counts overflows
// RULE_05 - tally saturates at 255
// RULE_06 - read-only result of last sync period
// RULE_07 - gain is eight low plus six high bits
// RULE_08 - samples scaled by gain over 1024
// RULE_09 - gain double-buffered, applied on gain sync
// RULE_10 - software should load peak control with 0x1d
// RULE_11 - overflow source: compensation, coarse, programmable
// RULE_12 - one count per qualifying event per cycle
`timescale 1ns/1ps
module dpm_top (
    input  wire logic                 clk_i,
    input  wire logic                 rst_b_i,
    // avalon-mm slave, word addressed
    input  wire logic [5:0]           avs_address_i,
    input  wire logic                 avs_read_i,
    input  wire logic                 avs_write_i,
    input  wire logic [31:0]          avs_writedata_i,
    input  wire logic [3:0]           avs_byteenable_i,
    output logic [31:0]               avs_readdata_o,
    output logic                      avs_waitrequest_o,
    // channel stream and chip sync logic
    input  wire dpm_pkg::dpm_sample_s sample_i,
    input  wire dpm_pkg::dpm_ovf_s    ovf_i,
    input  wire logic [1:0]           ovf_sel_i,
    input  wire logic [7:0]           sync_i,
    output dpm_pkg::dpm_sample_s      sample_o,
    output logic                      irq_o
);

    // ==========================================================
    // reset release
    // ==========================================================
    logic [1:0] rst_sync_r;
    wire        rst_b = rst_sync_r[1];

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    // ==========================================================
    // register state
    // ==========================================================
    dpm_pkg::dpm_peak_cfg_s peak_cfg_r;
    logic [7:0]             trim_lo_r;
    logic [5:0]             trim_hi_r;
    logic [2:0]             gain_sync_sel_r;
    logic [2:0]             irq_status_r;
    logic [2:0]             irq_status_nxt;
    logic [2:0]             irq_mask_r;
    logic                   irq_r;
    logic                   wait_r;
    logic [31:0]            rdata_r;
    logic [31:0]            rdata_nxt;

    // ==========================================================
    // bus decode
    // ==========================================================
    // one wait state: data are set up in the first cycle and the
    // access completes on the edge that sees waitrequest low
    wire req      = avs_read_i | avs_write_i;
    wire accept   = req && !wait_r;
    wire wr_low   = accept && avs_write_i && avs_byteenable_i[0];
    wire wr_ctrl  = wr_low && (avs_address_i == dpm_pkg::IDX_PEAK_CTRL);
    wire wr_tlo   = wr_low && (avs_address_i == dpm_pkg::IDX_TRIM_LO);
    wire wr_thi   = wr_low && (avs_address_i == dpm_pkg::IDX_TRIM_HI);
    wire wr_gsync = wr_low && (avs_address_i == dpm_pkg::IDX_GAIN_SYNC);
    wire wr_stat  = wr_low && (avs_address_i == dpm_pkg::IDX_IRQ_STATUS);
    wire wr_mask  = wr_low && (avs_address_i == dpm_pkg::IDX_IRQ_MASK);

    // ==========================================================
    // sync selection and submodules
    // ==========================================================
    wire       peak_sync = sync_i[peak_cfg_r.sync_sel];    // see RULE_01
    wire       gain_sync = sync_i[gain_sync_sel_r];        // see RULE_09
    wire [13:0] staged_gain = {trim_hi_r, trim_lo_r};      // see RULE_07
    wire [7:0] peak_result;
    wire       period_evt;
    wire       sat_evt;
    wire [13:0] active_gain;

    dpm_peak_counter u_peak (
        .clk_i     (clk_i),
        .rst_b_i   (rst_b),
        .cfg_i     (peak_cfg_r),
        .ovf_sel_i (ovf_sel_i),
        .sample_i  (sample_i),
        .ovf_i     (ovf_i),
        .sync_i    (peak_sync),
        .result_o  (peak_result),
        .period_o  (period_evt),
        .sat_o     (sat_evt)
    );

    dpm_trim_gain #(
        .GAIN_W (dpm_pkg::GAIN_W)
    ) u_gain (
        .clk_i    (clk_i),
        .rst_b_i  (rst_b),
        .staged_i (staged_gain),
        .load_i   (gain_sync),
        .sample_i (sample_i),
        .sample_o (sample_o),
        .active_o (active_gain)
    );

    // ==========================================================
    // interrupt status: a set in the clearing cycle survives
    // ==========================================================
    wire [2:0] irq_set = {sat_evt, gain_sync, period_evt};
    wire [2:0] irq_clr = wr_stat ? avs_writedata_i[2:0] : 3'h0;
    assign irq_status_nxt = (irq_status_r & ~irq_clr) | irq_set;

    // ==========================================================
    // read mux
    // ==========================================================
    // unmapped words read zero and swallow writes
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        case (avs_address_i)
            dpm_pkg::IDX_PEAK_CTRL:   rdata_nxt[7:0] = peak_cfg_r;
            dpm_pkg::IDX_PEAK_RESULT:
                rdata_nxt[7:0] = peak_result;       // see RULE_06
            dpm_pkg::IDX_TRIM_LO:     rdata_nxt[7:0] = trim_lo_r;
            dpm_pkg::IDX_TRIM_HI:     rdata_nxt[5:0] = trim_hi_r;
            dpm_pkg::IDX_IRQ_STATUS:  rdata_nxt[2:0] = irq_status_r;
            dpm_pkg::IDX_IRQ_MASK:    rdata_nxt[2:0] = irq_mask_r;
            dpm_pkg::IDX_GAIN_SYNC:   rdata_nxt[2:0] = gain_sync_sel_r;
            default:                  rdata_nxt = 32'h0000_0000;
        endcase
    end

    // ==========================================================
    // bus handshake
    // ==========================================================
    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            wait_r  <= 1'b1;
            rdata_r <= 32'h0000_0000;
        end else begin
            wait_r <= !(req && wait_r);
            // writes leave the last read data standing
            if (avs_read_i && wait_r) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    // ==========================================================
    // configuration registers
    // ==========================================================
    // staging bytes only; the active gain moves on the gain sync
    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            peak_cfg_r      <= dpm_pkg::RST_PEAK_CTRL;      // see RULE_10
            trim_lo_r       <= dpm_pkg::RST_TRIM_LO;
            trim_hi_r       <= dpm_pkg::RST_TRIM_HI[5:0];
            gain_sync_sel_r <= dpm_pkg::RST_GAIN_SYNC;
        end else begin
            if (wr_ctrl) begin
                peak_cfg_r <= {2'b00, avs_writedata_i[5:0]};
            end
            if (wr_tlo) begin
                trim_lo_r <= avs_writedata_i[7:0];          // see RULE_07
            end
            if (wr_thi) begin
                trim_hi_r <= avs_writedata_i[5:0];          // see RULE_07
            end
            if (wr_gsync) begin
                gain_sync_sel_r <= avs_writedata_i[2:0];
            end
        end
    end

    // ==========================================================
    // interrupt registers
    // ==========================================================
    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            irq_status_r <= dpm_pkg::RST_IRQ;
            irq_mask_r   <= dpm_pkg::RST_IRQ;
            irq_r        <= 1'b0;
        end else begin
            irq_status_r <= irq_status_nxt;
            if (wr_mask) begin
                irq_mask_r <= avs_writedata_i[2:0];
            end
            irq_r <= |(irq_status_nxt &
                       (wr_mask ? avs_writedata_i[2:0] : irq_mask_r));
        end
    end

    assign avs_waitrequest_o = wait_r;
    assign avs_readdata_o    = rdata_r;
    assign irq_o             = irq_r;

endmodule

/* logic/dpm_trim_gain.sv */
`timescale 1ns/1ps
module dpm_trim_gain #(
    parameter int GAIN_W = dpm_pkg::GAIN_W
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_b_i,
    input  wire logic [GAIN_W-1:0]    staged_i,
    input  wire logic                 load_i,
    input  wire dpm_pkg::dpm_sample_s sample_i,
    output dpm_pkg::dpm_sample_s      sample_o,
    output logic [GAIN_W-1:0]         active_o
);

    // ==========================================================
    // active gain and product
    // ==========================================================
    logic [GAIN_W-1:0]    active_r;
    dpm_pkg::dpm_sample_s out_r;
    wire signed [GAIN_W+16:0] product = sample_i.data *
                                        $signed({1'b0, active_r}); // see RULE_08
    wire signed [GAIN_W+6:0]  scaled  =
        product[GAIN_W+16:dpm_pkg::GAIN_SHIFT];            // see RULE_08
    // gain up to almost 16 can push past 16 bits, so clip
    wire over_pos = !scaled[GAIN_W+6] && (|scaled[GAIN_W+5:15]);
    wire over_neg =  scaled[GAIN_W+6] && !(&scaled[GAIN_W+5:15]);
    wire signed [15:0] clipped = over_pos ? 16'sh7fff :
                                 over_neg ? -16'sh8000 : scaled[15:0];

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            active_r <= '0;
            out_r    <= '0;
        end else begin
            if (load_i) begin
                active_r <= staged_i;                             // see RULE_09
            end
            out_r.valid <= sample_i.valid;
            out_r.data  <= clipped;
        end
    end

    assign sample_o = out_r;
    assign active_o = active_r;

endmodule

/* verif/dpm_chain_model.sv */
`timescale 1ns/1ps
module dpm_chain_model (
    input  wire logic            clk_i,
    input  wire logic            rst_b_i,
    input  wire logic            valid_i,
    input  wire logic [15:0]     data_i,
    input  wire logic [2:0]      ovf_i,
    input  wire logic [7:0]      sync_i,
    output dpm_pkg::dpm_sample_s sample_o,
    output dpm_pkg::dpm_ovf_s    ovf_o,
    output logic [7:0]           sync_o
);
    // ==========================================================
    // filter chain and sync logic output stage
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sample_o <= '0;
            ovf_o    <= '0;
            sync_o   <= '0;
        end else begin
            sample_o.valid <= valid_i;
            // idle words toggle so a stale word never looks valid
            sample_o.data  <= valid_i ? data_i : ~sample_o.data;
            ovf_o          <= ovf_i;
            sync_o         <= sync_i;
        end
    end
endmodule

/* verif/dpm_checker.sv */
`timescale 1ns/1ps
module dpm_checker (
    input wire logic                 clk_i,
    input wire logic                 rst_b_i,
    input wire logic [5:0]           avs_address_i,
    input wire logic                 avs_read_i,
    input wire logic                 avs_write_i,
    input wire logic [31:0]          avs_readdata_o,
    input wire logic                 avs_waitrequest_o,
    input wire dpm_pkg::dpm_sample_s sample_i,
    input wire dpm_pkg::dpm_sample_s sample_o
);
    // ==========================================================
    // bus and stream properties
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_req;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence
    sequence s_done;
        !avs_waitrequest_o ##1 avs_waitrequest_o;
    endsequence
    a_req_answered: assert property (s_req |=> s_done)
        else $error("request not answered in one cycle");
    a_wait_one: assert property (
        !avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low too long");
    a_rd_hold: assert property (
        $changed(avs_readdata_o)
        |-> $past(avs_read_i && avs_waitrequest_o))
        else $error("read data moved without a read");
    a_trim_top: assert property (
        avs_read_i && !avs_waitrequest_o
        && avs_address_i == dpm_pkg::IDX_TRIM_HI
        |-> avs_readdata_o[31:6] == 26'h0)
        else $error("unused gain bits read nonzero");
    a_ctrl_top: assert property (
        avs_read_i && !avs_waitrequest_o
        && avs_address_i == dpm_pkg::IDX_PEAK_CTRL
        |-> avs_readdata_o[31:6] == 26'h0)
        else $error("unused control bits read nonzero");
    a_valid_delay: assert property (
        sample_i.valid |=> sample_o.valid)
        else $error("gained sample not one cycle later");
    a_zero_in: assert property (
        sample_i.valid && sample_i.data == 16'h0
        |=> sample_o.data == 16'h0)
        else $error("zero sample gave nonzero output");
    a_sign_kept: assert property (
        sample_i.valid && !sample_i.data[15]
        |=> !sample_o.data[15])
        else $error("positive sample turned negative");
endmodule
bind dpm_top dpm_checker i_chk (
    .clk_i             (clk_i),
    .rst_b_i           (rst_b_i),
    .avs_address_i     (avs_address_i),
    .avs_read_i        (avs_read_i),
    .avs_write_i       (avs_write_i),
    .avs_readdata_o    (avs_readdata_o),
    .avs_waitrequest_o (avs_waitrequest_o),
    .sample_i          (sample_i),
    .sample_o          (sample_o)
);

/* verif/dpm_top_tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin \
    mismatches++; $display("BAD %0t got %0h want %0h", $time, a, b); \
    end end
module dpm_top_tb;
    logic               clk_i = 0;
    logic               rst_b_i = 0;
    logic [5:0]         adr = 6'h0;
    logic               rd = 0;
    logic               wr = 0;
    logic [31:0]        wdat = 32'h0;
    logic [31:0]        rdat;
    logic               wt;
    logic               pv = 0;
    logic signed [15:0] pd = 16'h0;
    logic [2:0]         po = 3'h0;
    logic [7:0]         ps = 8'h0;
    logic [1:0]         osel = 2'h0;
    logic [7:0]         q;
    logic               irq;
    logic [7:0]         s_sync;
    dpm_pkg::dpm_sample_s s_in;
    dpm_pkg::dpm_sample_s s_out;
    dpm_pkg::dpm_ovf_s    o_in;
    int                 mismatches = 0;
    int                 n_checks = 0;
    always #2.5 clk_i = ~clk_i;
    dpm_top i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
        .avs_byteenable_i(4'hf), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wt), .sample_i(s_in), .ovf_i(o_in),
        .ovf_sel_i(osel), .sync_i(s_sync), .sample_o(s_out), .irq_o(irq));
    dpm_chain_model i_far (.clk_i(clk_i), .rst_b_i(rst_b_i), .valid_i(pv),
        .data_i(pd), .ovf_i(po), .sync_i(ps), .sample_o(s_in),
        .ovf_o(o_in), .sync_o(s_sync));
    // ==========================================================
    // shared drivers
    task automatic bus(input logic w, input logic [5:0] a,
                       input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        adr  <= a;
        wdat <= {24'ha5a5a5, d};
        wr   <= w;
        rd   <= !w;
        @(posedge clk_i);
        while (wt !== 1'b0 && n < 20) begin
            n++;
            @(posedge clk_i);
        end
        q = rdat[7:0];
        wr <= 0;
        rd <= 0;
        `CHK(n < 20, 1'b1)
    endtask
    task automatic sync(input logic [7:0] m);
        @(posedge clk_i);
        ps <= m;
        @(posedge clk_i);
        ps <= 8'h0;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic push(input logic signed [15:0] ds[$]);
        foreach (ds[i]) begin
            @(posedge clk_i);
            pv <= 1;
            pd <= ds[i];
        end
        @(posedge clk_i);
        pv <= 0;
        repeat (3) @(posedge clk_i);
    endtask
    function automatic logic [15:0] gained(input int d, input int g);
        longint p;
        p = (longint'(d) * g) >>> 10;
        if (p > 32767) p = 32767;
        if (p < -32768) p = -32768;
        return p[15:0];
    endfunction
    task automatic one(input int d, input logic [15:0] e);
        @(posedge clk_i);
        pv <= 1;
        pd <= 16'(d);
        @(posedge clk_i);
        pv <= 0;
        @(posedge clk_i);
        #1;
        `CHK(s_out.data, e)
    endtask
    // ==========================================================
    // scenarios
    task automatic t_regs();
        bus(0, dpm_pkg::IDX_PEAK_CTRL, 0);
        `CHK(q, dpm_pkg::RST_PEAK_CTRL)
        bus(1, dpm_pkg::IDX_TRIM_HI, 8'hff);
        bus(0, dpm_pkg::IDX_TRIM_HI, 0);
        `CHK(q, 8'h3f)
        bus(1, dpm_pkg::IDX_PEAK_RESULT, 8'h5a);
        bus(0, dpm_pkg::IDX_PEAK_RESULT, 0);
        `CHK(q, 8'h00)
        bus(1, 6'h3f, 8'h5a);
        bus(0, 6'h3f, 0);
        `CHK(q, 8'h00)
        bus(1, dpm_pkg::IDX_TRIM_HI, 8'h00);
    endtask
    task automatic t_level();
        logic signed [15:0] ds[$];
        logic signed [10:0] tv;
        logic [7:0]         prev;
        int                 thr;
        int                 ex;
        int                 lst[7];
        for (int c = 0; c < 4; c++) begin
            thr = (c + 1) * 256;
            lst = '{thr - 1, thr, 1 - thr, -thr, 1023, -1024, 0};
            bus(1, dpm_pkg::IDX_PEAK_CTRL, {5'(c), 3'(c + 1)});
            sync(8'(1 << (c + 1)));
            bus(0, dpm_pkg::IDX_PEAK_RESULT, 0);
            prev = q;
            ds = {};
            ex = 0;
            foreach (lst[i]) begin
                ds.push_back(16'((lst[i] << 5) | 31));
                tv = ds[i][15:5];
                if (int'(tv) >= thr || -int'(tv) >= thr) ex++;
            end
            push(ds);
            sync(~8'(1 << (c + 1)));
            bus(0, dpm_pkg::IDX_PEAK_RESULT, 0);
            `CHK(q, prev)
            sync(8'(1 << (c + 1)));
            bus(0, dpm_pkg::IDX_PEAK_RESULT, 0);
            `CHK(q, 8'(ex))
        end
    endtask
    task automatic t_ovf();
        logic [2:0] pat[6] = '{3'h1, 3'h2, 3'h2, 3'h4, 3'h4, 3'h4};
        int         ex[4] = '{1, 2, 3, 3};
        bus(1, dpm_pkg::IDX_PEAK_CTRL, 8'h20);
        for (int s = 0; s < 4; s++) begin
            osel <= 2'(s);
            sync(8'h01);
            foreach (pat[i]) begin
                @(posedge clk_i);
                po <= pat[i];
                pv <= 1;
                pd <= 16'h8000;
            end
            @(posedge clk_i);
            po <= 3'h0;
            pv <= 0;
            sync(8'h01);
            bus(0, dpm_pkg::IDX_PEAK_RESULT, 0);
            `CHK(q, 8'(ex[s]))
        end
    endtask
    task automatic t_sat();
        logic signed [15:0] ds[$];
        repeat (300) ds.push_back(16'h8000);
        bus(1, dpm_pkg::IDX_PEAK_CTRL, 8'h00);
        sync(8'h01);
        push(ds);
        sync(8'h01);
        bus(0, dpm_pkg::IDX_PEAK_RESULT, 0);
        `CHK(q, dpm_pkg::TALLY_MAX)
        `CHK(irq, 1'b0)
        bus(1, dpm_pkg::IDX_IRQ_MASK, 8'(1 << dpm_pkg::IRQ_SAT));
        repeat (2) @(posedge clk_i);
        `CHK(irq, 1'b1)
        bus(0, dpm_pkg::IDX_IRQ_STATUS, 0);
        `CHK(q, 8'h07)
        bus(1, dpm_pkg::IDX_IRQ_STATUS, 8'h07);
        repeat (2) @(posedge clk_i);
        `CHK(irq, 1'b0)
        bus(0, dpm_pkg::IDX_IRQ_STATUS, 0);
        `CHK(q, 8'h00)
    endtask
    task automatic t_gain();
        int gs[5] = '{2048, 16383, 16383, 16383, 677};
        int dv[5] = '{1000, 100, 30000, -30000, -3};
        int g;
        g = 0;
        bus(1, dpm_pkg::IDX_GAIN_SYNC, 8'h02);
        foreach (gs[i]) begin
            bus(1, dpm_pkg::IDX_TRIM_LO, 8'(gs[i]));
            bus(1, dpm_pkg::IDX_TRIM_HI, 8'(gs[i] >> 8));
            sync(8'hfb);
            one(dv[i], gained(dv[i], g));
            sync(8'h04);
            g = gs[i];
            one(dv[i], gained(dv[i], g));
        end
        one(0, 16'h0000);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        finish_test();
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_b_i <= 1;
        repeat (4) @(posedge clk_i);
        t_regs();
        t_level();
        t_ovf();
        t_sat();
        t_gain();
        finish_test();
    end
endmodule
